// ### underexcitation_reactive_power_guard.sv
// The register addresses and the plain strobed port were left to the implementer.
`default_nettype none
module underexcitation_reactive_power_guard #(
  parameter int REC_DEPTH = 12
) (
  input  wire logic                    clk_i,        // Program timebase clock.
  input  wire logic                    rst_i,        // Async reset, high.
  input  wire logic                    ce_i,         // Clock enable.
  input  wire logic                    cycle_i,      // Program cycle strobe.
  input  wire logic                    block_i,      // Block from matrix.
  input  wire logic signed [31:0]      q_meas_i,     // 3-ph Q, 0.01 kvar.
  input  wire logic signed [31:0]      p_meas_i,     // 3-ph P, 0.01 kW.
  input  wire logic [31:0]             time_i,       // Timestamp.
  input  wire logic [2:0]              group_i,      // Setting group.
  input  wire logic                    force_en_i,   // Stage forcing on.
  input  wire logic [uex_pkg::AW-1:0]  addr_i,       // Register index.
  input  wire logic [31:0]             wdata_i,      // Write data.
  input  wire logic                    wr_i,         // Write strobe.
  input  wire logic                    rd_i,         // Read strobe.
  output logic [31:0]                  rdata_o,      // Read data.
  output uex_pkg::status_e             status_o,     // Condition.
  output logic                         start_o,      // Start.
  output logic                         trip_o,       // Trip.
  output logic                         blocked_o,    // Blocked.
  output logic [uex_pkg::NEV-1:0]      event_o,      // Selected events.
  output logic [31:0]                  event_time_o, // Event stamp.
  output logic signed [31:0]           ratio_o,      // Q/Qset x100.
  output logic [31:0]                  remain_o,     // Steps to trip.
  output logic [31:0]                  expected_o    // Delay steps.
);
  import uex_pkg::*;
  localparam int PW = $clog2(REC_DEPTH);
  localparam int HD = PRE_FAULT_CYC;

  // The pointer arithmetic below needs at least two records.
  if (REC_DEPTH < 2 || REC_DEPTH > 16) begin : g_chk
    $error("REC_DEPTH must be 2 to 16");
  end

  // Settings group.
  logic [31:0] ctrl_r, ctrl_nxt;
  logic signed [31:0] q1_r, q1_nxt, p1_r, p1_nxt;
  logic signed [31:0] q2_r, q2_nxt, p2_r, p2_nxt;
  logic [31:0] delay_r, delay_nxt;
  logic [31:0] sel_r, sel_nxt;
  logic [2:0] clr;

  // Settings take effect on the very next clock, so a new group
  // loaded by software acts without stopping the stage.
  always_comb begin
    ctrl_nxt = ctrl_r;
    q1_nxt = q1_r;
    p1_nxt = p1_r;
    q2_nxt = q2_r;
    p2_nxt = p2_r;
    delay_nxt = delay_r;
    sel_nxt = sel_r;
    clr = 3'h0;
    if (wr_i) begin
      unique case (addr_i)
        A_CTRL:    ctrl_nxt = wdata_i;
        A_QSET1:   q1_nxt = wdata_i;
        A_PSET1:   p1_nxt = wdata_i;
        A_SECOND_POINT_REACTIVE_POWER:   q2_nxt = wdata_i;
        A_PSET2:   p2_nxt = wdata_i;
        A_DELAY:   delay_nxt = (wdata_i > MAX_STEPS) ? MAX_STEPS : wdata_i;
        A_CLEAR:   clr = wdata_i[2:0];
        A_REC_SEL: sel_nxt = wdata_i;
        default:   ;
      endcase
    end
  end

  // Settings registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      q1_r <= QSET_RST;
      p1_r <= PSET_RST;
      q2_r <= QSET_RST;
      p2_r <= PSET_RST;
      delay_r <= DELAY_RST;
      sel_r <= 32'h0;
    end else if (ce_i) begin
      ctrl_r <= ctrl_nxt;
      q1_r <= q1_nxt;
      p1_r <= p1_nxt;
      q2_r <= q2_nxt;
      p2_r <= p2_nxt;
      delay_r <= delay_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Characteristic arithmetic. The boundary is kept as num/den with
  // den positive, so no divider sits in the pick-up path.
  logic signed [33:0] dp;
  logic signed [79:0] den, num, lhs;
  logic pick_cond, rel_cond;
  logic signed [39:0] rq;
  logic signed [31:0] ratio_nxt;
  always_comb begin
    dp = 34'(p2_r) - 34'(p1_r);
    den = 80'sh1;
    num = 80'(q1_r);
    if (ctrl_r[MODE_BIT] && dp != 34'sh0) begin
      num = 80'(q1_r) * 80'(dp) + (80'(q2_r) - 80'(q1_r)) * (80'(p_meas_i) - 80'(p1_r));
      den = 80'(dp);
      if (dp < 34'sh0) begin
        num = -num;
        den = -den;
      end
    end
    lhs = 80'(q_meas_i) * den;
    pick_cond = lhs < num;
    rel_cond = (lhs * 80'(PCT_FULL)) > (num * 80'(RESET_PCT));
    rq = 40'sh0;
    if (q1_r != 32'sh0) begin
      rq = (40'(q_meas_i) * 40'(PCT_FULL)) / 40'(q1_r);
    end
    if (rq > 40'(RATIO_MAX)) begin
      ratio_nxt = RATIO_MAX;
    end else if (rq < -40'(RATIO_MAX)) begin
      ratio_nxt = -RATIO_MAX;
    end else begin
      ratio_nxt = 32'(rq);
    end
  end

  // Protection group.
  status_e st_r, st_nxt, eff;
  logic pick_r, pick_nxt;
  logic [31:0] cnt_r, cnt_nxt, rem_nxt;
  logic start_nxt, trip_nxt, blk_nxt;
  logic [NEV-1:0] raw, ev_nxt;
  logic [31:0] evt_nxt;
  logic signed [31:0] ratio_r;
  logic [31:0] remain_r, expect_r;

  // Block is looked at together with the pick-up result in the same
  // program cycle, so a block present at pick-up never shows start.
  always_comb begin
    st_nxt = st_r;
    pick_nxt = pick_r;
    cnt_nxt = cnt_r;
    if (cycle_i) begin
      pick_nxt = pick_r ? !rel_cond : pick_cond;
      if (!pick_nxt) begin
        st_nxt = ST_NORMAL;
        cnt_nxt = 32'h0;
      end else if (block_i) begin
        st_nxt = ST_BLOCKED;
        cnt_nxt = 32'h0;
      end else if (st_r == ST_NORMAL || st_r == ST_BLOCKED) begin
        cnt_nxt = 32'h0;
        st_nxt = (delay_r == 32'h0) ? ST_TRIP : ST_START;
      end else if (st_r == ST_START) begin
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_nxt >= delay_r) begin
          st_nxt = ST_TRIP;
        end
      end
    end
    rem_nxt = (st_nxt == ST_START) ? delay_r - cnt_nxt : 32'h0;
    eff = force_en_i ? status_e'(ctrl_r[FORCE_LSB +: 2]) : st_nxt;
    start_nxt = (eff == ST_START) || (eff == ST_TRIP);
    trip_nxt = (eff == ST_TRIP);
    blk_nxt = (eff == ST_BLOCKED);
    raw[EV_START_ON] = start_nxt && !start_o;
    raw[EV_START_OFF] = !start_nxt && start_o;
    raw[EV_TRIP_ON] = trip_nxt && !trip_o;
    raw[EV_TRIP_OFF] = !trip_nxt && trip_o;
    raw[EV_BLK_ON] = blk_nxt && !blocked_o;
    raw[EV_BLK_OFF] = !blk_nxt && blocked_o;
    ev_nxt = raw & ctrl_r[EVSEL_LSB +: NEV];
    evt_nxt = (raw != '0) ? time_i : event_time_o;
  end

  // Protection registers; all outputs except rdata_o leave straight from here.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_NORMAL;
      pick_r <= 1'b0;
      cnt_r <= 32'h0;
      status_o <= ST_NORMAL;
      start_o <= 1'b0;
      trip_o <= 1'b0;
      blocked_o <= 1'b0;
      event_o <= '0;
      event_time_o <= 32'h0;
      ratio_r <= 32'sh0;
      remain_r <= 32'h0;
      expect_r <= DELAY_RST;
    end else if (ce_i) begin
      st_r <= st_nxt;
      pick_r <= pick_nxt;
      cnt_r <= cnt_nxt;
      status_o <= eff;
      start_o <= start_nxt;
      trip_o <= trip_nxt;
      blocked_o <= blk_nxt;
      event_o <= ev_nxt;
      event_time_o <= evt_nxt;
      ratio_r <= ratio_nxt;
      remain_r <= rem_nxt;
      expect_r <= delay_r;
    end
  end
  assign ratio_o = ratio_r;
  assign remain_o = remain_r;
  assign expected_o = expect_r;

  // Counters: an occurrence in the clearing cycle is kept as one.
  logic [31:0] cnt3_r [3];
  logic [31:0] cnt3_nxt [3];
  logic [2:0] inc;
  always_comb begin
    inc = {raw[EV_BLK_ON], raw[EV_TRIP_ON], raw[EV_START_ON]};
    for (int i = 0; i < 3; i++) begin
      if (clr[i]) begin
        cnt3_nxt[i] = {31'h0, inc[i]};
      end else begin
        cnt3_nxt[i] = cnt3_r[i] + {31'h0, inc[i]};
      end
    end
  end

  // Counter registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt3_r <= '{default: 32'h0};
    end else if (ce_i) begin
      cnt3_r <= cnt3_nxt;
    end
  end

  // Power history, one entry per program cycle; entry 0 is the
  // previous cycle, so the pre-trigger tap sits PRE_TRIG_CYC-1 deep.
  logic signed [31:0] hp_r [HD];
  logic signed [31:0] hq_r [HD];
  logic signed [31:0] hp_nxt [HD];
  logic signed [31:0] hq_nxt [HD];
  always_comb begin
    hp_nxt = hp_r;
    hq_nxt = hq_r;
    if (cycle_i) begin
      hp_nxt[0] = p_meas_i;
      hq_nxt[0] = q_meas_i;
      for (int i = 1; i < HD; i++) begin
        hp_nxt[i] = hp_r[i-1];
        hq_nxt[i] = hq_r[i-1];
      end
    end
  end

  // History registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hp_r <= '{default: 32'h0};
      hq_r <= '{default: 32'h0};
    end else if (ce_i) begin
      hp_r <= hp_nxt;
      hq_r <= hq_nxt;
    end
  end

  // Fault records. Simultaneous ON events share one record whose tag
  // carries every ON bit, trading detail for a single write port.
  logic [31:0] rec_r [REC_DEPTH][NFIELD];
  logic [31:0] rec_nxt [REC_DEPTH][NFIELD];
  logic [PW-1:0] wp_r, wp_nxt;
  logic [PW:0] fill_r, fill_nxt;
  logic [2:0] on3;
  always_comb begin
    rec_nxt = rec_r;
    wp_nxt = wp_r;
    fill_nxt = fill_r;
    on3 = {raw[EV_BLK_ON], raw[EV_TRIP_ON], raw[EV_START_ON]};
    if (on3 != 3'h0) begin
      rec_nxt[wp_r][F_TIME] = time_i;
      rec_nxt[wp_r][F_TAG] = {25'h0, group_i, 1'b0, on3};
      rec_nxt[wp_r][F_P20] = hp_r[PRE_TRIG_CYC-1];
      rec_nxt[wp_r][F_Q20] = hq_r[PRE_TRIG_CYC-1];
      rec_nxt[wp_r][F_PF] = p_meas_i;
      rec_nxt[wp_r][F_QF] = q_meas_i;
      rec_nxt[wp_r][F_P200] = hp_r[PRE_FAULT_CYC-1];
      rec_nxt[wp_r][F_Q200] = hq_r[PRE_FAULT_CYC-1];
      rec_nxt[wp_r][F_REM] = rem_nxt;
      wp_nxt = (wp_r == PW'(REC_DEPTH - 1)) ? '0 : wp_r + PW'(1);
      if (fill_r != (PW+1)'(REC_DEPTH)) begin
        fill_nxt = fill_r + (PW+1)'(1);
      end
    end
  end

  // Record registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rec_r <= '{default: '{default: 32'h0}};
      wp_r <= '0;
      fill_r <= '0;
    end else if (ce_i) begin
      rec_r <= rec_nxt;
      wp_r <= wp_nxt;
      fill_r <= fill_nxt;
    end
  end

  // Read port: data stands in the cycle after the strobe only.
  logic [31:0] rdata_nxt;
  int ent;
  int fld;
  always_comb begin
    ent = (int'(wp_r) + 2 * REC_DEPTH - 1 - int'(sel_r[PW:0])) % REC_DEPTH;
    fld = int'(addr_i) - int'(A_REC0);
    rdata_nxt = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        A_CTRL:    rdata_nxt = ctrl_r;
        A_QSET1:   rdata_nxt = q1_r;
        A_PSET1:   rdata_nxt = p1_r;
        A_SECOND_POINT_REACTIVE_POWER:   rdata_nxt = q2_r;
        A_PSET2:   rdata_nxt = p2_r;
        A_DELAY:   rdata_nxt = delay_r;
        A_STATUS:  rdata_nxt = {26'h0, pick_r, blocked_o, trip_o, start_o, status_o};
        A_RATIO:   rdata_nxt = ratio_r;
        A_REMAIN:  rdata_nxt = remain_r;
        A_EXPECT:  rdata_nxt = expect_r;
        A_REC_SEL: rdata_nxt = sel_r;
        A_REC_CNT: rdata_nxt = 32'(fill_r);
        default: begin
          if (addr_i >= A_CNT0 && addr_i < A_CLEAR) begin
            rdata_nxt = cnt3_r[int'(addr_i) - int'(A_CNT0)];
          end else if (fld >= 0 && fld < NFIELD && sel_r < 32'(fill_r)) begin
            rdata_nxt = rec_r[ent][fld];
          end
        end
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (ce_i) begin
      rdata_o <= rdata_nxt;
    end
  end
endmodule // underexcitation_reactive_power_guard
`default_nettype wire

// ### uex_pkg.sv
// Operation
// - Pick up when measured reactive power falls below the threshold.
// - Release only when power climbs back past 97 % of the threshold.
// - Mode bit selects fixed threshold or two-point characteristic, fixed by default.
// - First reactive setting, 0.01 kvar steps, default -100 kvar.
// - First point active power, 0.01 kW steps, default 100 kW.
// - Second point: reactive default -100 kvar, active default 100 kW.
// - Setting changes apply while running, without a restart.
// - Report condition as normal, start, trip or blocked.
// - Expose expected operating time in 5 ms steps, at most 1800 s.
// - While timing, expose time left to trip in 5 ms steps.
// - Expose measured power over threshold ratio in 0.01 steps.
// - Sample the block input at each program cycle before evaluating pick-up.
// - Unblocked pick-up asserts start and begins operate timing.
// - Blocked pick-up asserts blocked and goes no further.
// - Block arriving during start clears start like a pick-up release.
// - Trip timing is definite time only.
// - Timestamped event on each edge of start, trip and blocked.
// - Per-event selection of which edges reach the main event buffer.
// - Separate resettable counters for start, trip and blocked.
// - Each ON event stores a record; twelve newest kept, oldest overwritten. Simultaneous ON events share one record here.
// - Record holds time, event, powers at -20 ms, event, -200 ms, remaining, group.
// - Measured quantity is total three-phase reactive power.
// - Global forcing overrides reported status with a selected state, normal by default.
`default_nettype none
package uex_pkg;
  typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED} status_e;
  localparam int unsigned AW = 5;
  localparam logic [4:0] A_CTRL    = 5'h00;
  localparam logic [4:0] A_QSET1   = 5'h01;
  localparam logic [4:0] A_PSET1   = 5'h02;
  localparam logic [4:0] A_SECOND_POINT_REACTIVE_POWER   = 5'h03;
  localparam logic [4:0] A_PSET2   = 5'h04;
  localparam logic [4:0] A_DELAY   = 5'h05;
  localparam logic [4:0] A_STATUS  = 5'h06;
  localparam logic [4:0] A_RATIO   = 5'h07;
  localparam logic [4:0] A_REMAIN  = 5'h08;
  localparam logic [4:0] A_EXPECT  = 5'h09;
  localparam logic [4:0] A_CNT0    = 5'h0A;
  localparam logic [4:0] A_CLEAR   = 5'h0D;
  localparam logic [4:0] A_REC_SEL = 5'h0E;
  localparam logic [4:0] A_REC_CNT = 5'h0F;
  localparam logic [4:0] A_REC0    = 5'h10;
  localparam int unsigned MODE_BIT  = 0;
  localparam int unsigned FORCE_LSB = 1;
  localparam int unsigned EVSEL_LSB = 4;
  localparam int unsigned NEV       = 6;
  localparam logic [31:0] CTRL_RST  = 32'h0000_03F0;
  localparam logic [31:0] QSET_RST  = 32'hFFFF_D8F0;
  localparam logic [31:0] PSET_RST  = 32'h0000_2710;
  localparam int STEP_MS      = 5;
  localparam int DEF_DELAY_MS = 40;
  localparam int MAX_DELAY_MS = 1800000;
  localparam int PRE_TRIG_MS  = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam logic [31:0] DELAY_RST = 32'(DEF_DELAY_MS / STEP_MS);
  localparam logic [31:0] MAX_STEPS = 32'(MAX_DELAY_MS / STEP_MS);
  localparam int PRE_TRIG_CYC  = PRE_TRIG_MS / STEP_MS;
  localparam int PRE_FAULT_CYC = PRE_FAULT_MS / STEP_MS;
  localparam int PCT_FULL  = 100;
  localparam int RESET_PCT = 97;
  localparam int RATIO_MAX = 125000;
  localparam int EV_START_ON = 0;
  localparam int EV_START_OFF = 1;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_TRIP_OFF = 3;
  localparam int EV_BLK_ON = 4;
  localparam int EV_BLK_OFF = 5;
  localparam int F_TIME = 0;
  localparam int F_TAG  = 1;
  localparam int F_P20  = 2;
  localparam int F_Q20  = 3;
  localparam int F_PF   = 4;
  localparam int F_QF   = 5;
  localparam int F_P200 = 6;
  localparam int F_Q200 = 7;
  localparam int F_REM  = 8;
  localparam int NFIELD = 9;
  localparam int GRP_LSB = 4;
endpackage
`default_nettype wire

// ### uex_power_source.sv
`default_nettype none
module uex_power_source #(
  parameter int CYC = 4
) (
  input  wire logic               clk_i,     // Clock.
  input  wire logic               rst_i,     // Reset.
  input  wire logic signed [31:0] q_set_i,   // Commanded Q.
  input  wire logic signed [31:0] p_set_i,   // Commanded P.
  input  wire logic               blk_set_i, // Commanded block.
  output logic                    cycle_o,   // Program cycle pulse.
  output logic signed [31:0]      q_o,       // Measured total Q.
  output logic signed [31:0]      p_o,       // Measured P.
  output logic                    blk_o,     // Block level.
  output logic [31:0]             time_o     // Stamp.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;

  // The chain refreshes its results every clock, so a short program cycle keeps the run brief.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r   <= 8'h00;
      cycle_o <= 1'b0;
      q_o     <= 32'sh0;
      p_o     <= 32'sh0;
      blk_o   <= 1'b0;
      time_o  <= 32'h0;
    end else begin
      cnt_r   <= (cnt_r == 8'(CYC - 1)) ? 8'h00 : cnt_r + 8'h01;
      cycle_o <= (cnt_r == 8'(CYC - 1));
      q_o     <= q_set_i;
      p_o     <= p_set_i;
      blk_o   <= blk_set_i;
      time_o  <= time_o + 32'h1;
    end
  end
endmodule // uex_power_source
`default_nettype wire

// ### uex_checker_props.sv
`default_nettype none
module uex_checker
  import uex_pkg::*;
#(
  parameter int REC_DEPTH = 12
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 cycle_i,
  input wire logic                 force_en_i,
  input wire logic [31:0]          time_i,
  input wire uex_pkg::status_e     status_o,
  input wire logic                 start_o,
  input wire logic                 trip_o,
  input wire logic                 blocked_o,
  input wire logic [NEV-1:0]       event_o,
  input wire logic [31:0]          event_time_o,
  input wire logic signed [31:0]   ratio_o,
  input wire logic [31:0]          remain_o,
  input wire logic [31:0]          expected_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Unforced edges only; forcing may move the outputs at any clock.
  sequence s_start_rise;
    $rose(start_o) && !trip_o && !force_en_i && !$past(force_en_i);
  endsequence
  sequence s_trip_rise;
    $rose(trip_o) && $past(start_o) && !force_en_i && !$past(force_en_i);
  endsequence

  property p_trip_start; trip_o |-> start_o; endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  property p_status_lv; status_o == ST_START |-> start_o && !trip_o && !blocked_o; endproperty
  a_status_lv: assert property (p_status_lv) else $error("status and levels disagree");
  property p_blk_excl; blocked_o |-> !start_o; endproperty
  a_blk_excl: assert property (p_blk_excl) else $error("blocked while started");
  property p_hold;
    !$past(cycle_i) && !$past(force_en_i) && !$past(force_en_i, 2) && !force_en_i
      |-> $stable(start_o) && $stable(trip_o) && $stable(blocked_o);
  endproperty
  a_hold: assert property (p_hold) else $error("levels moved between cycles");
  property p_start_remain; s_start_rise |-> remain_o == expected_o; endproperty
  a_start_remain: assert property (p_start_remain) else $error("timer not loaded at start");
  property p_trip_time; s_trip_rise |-> $past(remain_o) == 32'h1 && remain_o == 32'h0; endproperty
  a_trip_time: assert property (p_trip_time) else $error("trip at wrong count");
  property p_idle_remain; !start_o && !force_en_i && !$past(force_en_i) |-> remain_o == 32'h0; endproperty
  a_idle_remain: assert property (p_idle_remain) else $error("time left while idle");
  property p_ev_edges;
    (event_o[0] -> $rose(start_o)) && (event_o[1] -> $fell(start_o)) && (event_o[2] -> $rose(trip_o))
      && (event_o[3] -> $fell(trip_o)) && (event_o[4] -> $rose(blocked_o)) && (event_o[5] -> $fell(blocked_o));
  endproperty
  a_ev_edges: assert property (p_ev_edges) else $error("event without edge");
  property p_ev_time; |event_o |-> event_time_o == $past(time_i); endproperty
  a_ev_time: assert property (p_ev_time) else $error("event stamp wrong");
  property p_ratio; ratio_o <= RATIO_MAX && ratio_o >= -RATIO_MAX; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio out of range");
  property p_exp; expected_o <= MAX_STEPS; endproperty
  a_exp: assert property (p_exp) else $error("expected time too long");
  c_trip: cover property (s_trip_rise);
endmodule // uex_checker
bind underexcitation_reactive_power_guard uex_checker #(.REC_DEPTH(REC_DEPTH)) u_chk (.*);
`default_nettype wire

// ### underexcitation_reactive_power_guard_test.sv
`default_nettype none
module underexcitation_reactive_power_guard_test;
  timeunit 1ns;
  timeprecision 1ps;
  import uex_pkg::*;
  logic clk_i, rst_i, ce_i, cycle_i, block_i, force_en_i, wr_i, rd_i, rd_d, blk_set;
  logic signed [31:0] q_meas_i, p_meas_i, q_set, p_set, ratio_o;
  logic [31:0] time_i, wdata_i, rdata_o, event_time_o, remain_o, expected_o;
  logic [2:0] group_i;
  logic [4:0] addr_i;
  logic start_o, trip_o, blocked_o;
  logic [NEV-1:0] event_o;
  status_e status_o;
  logic [31:0] exp_q[$];
  logic [7:0] lf = 8'd80;
  int failures = 0;
  int compares = 0;
  int i;
  logic [4:0] ra[9] = '{A_CTRL, A_QSET1, A_PSET1, A_SECOND_POINT_REACTIVE_POWER, A_PSET2, A_DELAY, A_EXPECT, A_STATUS, 5'h19};
  logic [31:0] re[9] = '{CTRL_RST, QSET_RST, PSET_RST, QSET_RST, PSET_RST, DELAY_RST, DELAY_RST, 32'h0, 32'h0};

  underexcitation_reactive_power_guard DUT (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .cycle_i      (cycle_i),
    .block_i      (block_i),
    .q_meas_i     (q_meas_i),
    .p_meas_i     (p_meas_i),
    .time_i       (time_i),
    .group_i      (group_i),
    .force_en_i   (force_en_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .wr_i         (wr_i),
    .rd_i         (rd_i),
    .rdata_o      (rdata_o),
    .status_o     (status_o),
    .start_o      (start_o),
    .trip_o       (trip_o),
    .blocked_o    (blocked_o),
    .event_o      (event_o),
    .event_time_o (event_time_o),
    .ratio_o      (ratio_o),
    .remain_o     (remain_o),
    .expected_o   (expected_o)
  );
  uex_power_source SRC (.clk_i(clk_i), .rst_i(rst_i), .q_set_i(q_set), .p_set_i(p_set), .blk_set_i(blk_set),
    .cycle_o(cycle_i), .q_o(q_meas_i), .p_o(p_meas_i), .blk_o(block_i), .time_o(time_i));

  // Free-running 50 MHz clock.
  always #10 clk_i = ~clk_i;

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // The note is queued before the strobe edge; the monitor takes it half a cycle after that edge.
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  // Group and, in fixed mode, the active power come from the sequence generator.
  task automatic drive(input logic signed [31:0] q, input logic signed [31:0] p, input logic b);
    @(posedge clk_i);
    q_set <= q;
    p_set <= p;
    blk_set <= b;
    group_i <= lf[2:0];
    lf = lfsr(lf);
  endtask

  task automatic wt(input int w, input logic v);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_i);
      if ((w == 0 ? start_o : w == 1 ? trip_o : blocked_o) === v) break;
    end
    if (n == 400) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Read data stand only in the cycle after the strobe, so look at mid-cycle.
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) if (rd_d === 1'b1) chk(rdata_o, exp_q.pop_front());

  initial begin
    {clk_i, ce_i, rst_i} = 3'b011;
    {wr_i, rd_i, blk_set, force_en_i} = '0;
    {addr_i, wdata_i, group_i, q_set, p_set} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 9; i++) rd(ra[i], re[i]);
    wr(A_DELAY, 32'h7FFF_FFFF);
    rd(A_EXPECT, MAX_STEPS);
    wr(A_DELAY, 32'd3);
    rd(A_EXPECT, 32'd3);
    done("reset");
    drive(-20000, 32'(lf), 1'b0);
    wt(0, 1'b1);
    rd(A_STATUS, 32'h25);
    wt(1, 1'b1);
    rd(A_STATUS, 32'h2E);
    rd(A_CNT0, 32'd1);
    rd(5'h0B, 32'd1);
    rd(A_REC_CNT, 32'd2);
    drive(-9800, 32'(lf), 1'b0);
    repeat (12) @(posedge clk_i);
    rd(A_STATUS, 32'h2E);
    rd(A_RATIO, 32'd98);
    drive(-9600, 32'(lf), 1'b0);
    wt(0, 1'b0);
    rd(A_STATUS, 32'h0);
    done("trip");
    wr(A_DELAY, 32'd50);
    drive(-20000, 32'(lf), 1'b1);
    wt(2, 1'b1);
    rd(A_STATUS, 32'h33);
    drive(-20000, 32'(lf), 1'b0);
    wt(0, 1'b1);
    drive(-20000, 32'(lf), 1'b1);
    wt(2, 1'b1);
    rd(A_REMAIN, 32'h0);
    rd(A_STATUS, 32'h33);
    drive(-5000, 32'(lf), 1'b0);
    wt(2, 1'b0);
    rd(A_CNT0, 32'd2);
    rd(5'h0C, 32'd2);
    done("block");
    wr(A_PSET1, 32'h0);
    wr(A_SECOND_POINT_REACTIVE_POWER, -32'sd30000);
    wr(A_PSET2, 32'd10000);
    wr(A_CTRL, CTRL_RST | 32'h1);
    drive(-15000, 5000, 1'b0);
    repeat (12) @(posedge clk_i);
    rd(A_STATUS, 32'h0);
    drive(-15000, 0, 1'b0);
    wt(0, 1'b1);
    rd(A_STATUS, 32'h25);
    wr(A_CTRL, CTRL_RST);
    drive(-5000, 32'(lf), 1'b0);
    wt(0, 1'b0);
    done("two point");
    wr(A_CLEAR, 32'h7);
    for (i = 0; i < 3; i++) rd(A_CNT0 + 5'(i), 32'h0);
    for (i = 0; i < 13; i++) begin
      drive(-20000, 32'(lf), 1'b0);
      wt(0, 1'b1);
      drive(-5000, 32'(lf), 1'b0);
      wt(0, 1'b0);
    end
    rd(A_REC_CNT, 32'd12);
    rd(A_CNT0, 32'd13);
    rd(5'h15, 32'hFFFF_B1E0);
    rd(5'h18, 32'h0000_0032);
    done("records");
    wr(A_CTRL, CTRL_RST | 32'h4);
    @(posedge clk_i);
    force_en_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(A_STATUS, 32'h0E);
    force_en_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    // A write while the clock enable is low must leave the delay alone.
    ce_i <= 1'b0;
    wr(A_DELAY, 32'h0000_0005);
    ce_i <= 1'b1;
    rd(A_DELAY, 32'h0000_0032);
    done("forcing");
    wrap_up();
  end
endmodule // underexcitation_reactive_power_guard_test
`default_nettype wire
